// >>> shared/csp_defs.vh
// Overview of operation
// - clock select other than 111 makes the shift clock internally.
// - internal clock mode holds the serial clock pin high around transfers.
// - codes 000..110 give main clock over 2^13,2^8,2^6,2^5,2^4,2^3,2^2.
// - clock select 111 shifts on the clock arriving at the clock pin.
// - transmit bits change on the falling edge of the serial clock.
// - receive bits are sampled on the rising edge of the serial clock.
// - bit order 0 sends MSB first and stores the first bit as MSB.
// - bit order 1 sends LSB first and stores the first bit as LSB.
// - transfer mode 00 is transmit only.
// - transfer mode 01 is receive only, started without buffer preload.
// - internal clock starts at once; external shifts on incoming edges.
// - transmit interrupt fires as the second bit of the last byte starts.
// - run cleared in service finishes the byte, idle after last rise.
// - abort stops a transmission at once, even mid byte.
// - external fall with empty buffer sets transmit error, output high.
// - after an error abort clears only run and the status register.
// - abort clears run and all status flags, abort bit reads back 0.
`ifndef CSP_DEFS_VH
`define CSP_DEFS_VH
// register indexes, byte address is four times the index
`define CSP_IDX_CTL1     8'h16
`define CSP_IDX_CTL2     8'h17
`define CSP_IDX_STAT     8'h18
`define CSP_IDX_DATA     8'h19
// control one fields
`define CSP_CTL1_RUN     7
`define CSP_CTL1_ABORT   6
`define CSP_CTL1_MODE_HI 5
`define CSP_CTL1_MODE_LO 4
`define CSP_CTL1_DIR     3
`define CSP_CTL1_SCK_HI  2
`define CSP_CTL1_SCK_LO  0
`define CSP_CTL1_RST     8'h00
`define CSP_CTL2_RST     3'h0
// status fields
`define CSP_ST_ACTIVE    7
`define CSP_ST_SHIFT     6
`define CSP_ST_TXEMPTY   5
`define CSP_ST_RXFULL    4
`define CSP_ST_TXERR     3
`define CSP_ST_RXERR     2
// codes
`define CSP_MODE_TX      2'h0
`define CSP_MODE_RX      2'h1
`define CSP_MODE_TXRX    2'h2
`define CSP_SCK_EXT      3'h7
`define CSP_BUF_DEPTH    8
`define CSP_BUF_AW       3
`endif

// >>> logic/csp_buf.v
`timescale 1ns/100ps
module csp_buf
(
	// clock and reset
	input  wire       clk,
	input  wire       rst,
	// control
	input  wire       push,
	input  wire       pop,
	input  wire [7:0] wdata,
	// state
	output wire [7:0] rdata,
	output wire       empty,
	output wire       full
);
`include "csp_defs.vh"
	reg [7:0]              mem [0:`CSP_BUF_DEPTH-1];
	reg [`CSP_BUF_AW-1:0]  wptr;
	reg [`CSP_BUF_AW-1:0]  rptr;
	reg [`CSP_BUF_AW:0]    cnt;
	wire                   do_push;
	wire                   do_pop;

	// a push into a full buffer is dropped rather than overwrite data
	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;
	assign empty   = (cnt == 4'h0);
	assign full    = (cnt == 4'h8);
	assign rdata   = mem[rptr];

	always @(posedge clk)
	begin
		if (do_push)
			mem[wptr] <= wdata;
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wptr <= 3'h0;
			rptr <= 3'h0;
			cnt  <= 4'h0;
		end
		else
		begin
			if (do_push)
				wptr <= wptr + 3'h1;
			if (do_pop)
				rptr <= rptr + 3'h1;
			if (do_push & ~do_pop)
				cnt <= cnt + 4'h1;
			else if (do_pop & ~do_push)
				cnt <= cnt - 4'h1;
		end
	end
endmodule

// >>> logic/csp_top.v
`timescale 1ns/100ps
module csp_top
(
	// clock and reset
	input  wire        REF_CLK,
	input  wire        SYS_RST,
	// apb slave
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	// serial pins
	input  wire        SERIAL_CLOCK_PIN_IN,
	output reg         SERIAL_CLOCK_PIN_OUT,
	output reg         SERIAL_CLOCK_PIN_OE_N,
	input  wire        SERIAL_DATA_IN,
	output reg         SERIAL_DATA_OUTPUT_PIN,
	// event
	output reg         TRANSFER_INTERRUPT
);
`include "csp_defs.vh"
	reg  [7:0]  serial_control_one;
	reg  [2:0]  serial_control_two;
	reg         active;
	reg         shifting;
	reg         tx_empty;
	reg         rx_full;
	reg         tx_err;
	reg         rx_err;
	reg  [2:0]  bit_cnt;
	reg  [3:0]  byte_cnt;
	reg  [7:0]  shreg;
	reg  [12:0] div;
	reg         sck_int;
	reg         ck_s1;
	reg         ck_s2;
	reg         ck_s3;
	reg         ck_st;
	reg         di_s1;
	reg         di_s2;
	reg         di_s3;
	wire        run;
	wire        dir;
	wire [1:0]  mode;
	wire        ext;
	wire        tx_mode;
	wire        rx_mode;
	wire [3:0]  total;
	wire        done_all;
	wire        gen;
	wire        tick;
	wire        lead;
	wire        trail;
	wire [7:0]  next_shreg;
	wire        acc;
	wire        wr;
	wire        rd;
	wire        hit_data;
	wire        mapped;
	wire [7:0]  idx;
	wire        abort;
	wire        load;
	wire        byte_end;
	wire [7:0]  buf_rdata;
	wire        buf_empty;
	wire        buf_push;
	wire        buf_pop;
	wire [7:0]  buf_wdata;
	wire [7:0]  stat;

	// half period of the internal shift clock in main clock cycles
	function [12:0] half_cnt;
		input [2:0] code;
		begin
			case (code)
				3'h0:    half_cnt = 13'h1000;
				3'h1:    half_cnt = 13'h0080;
				3'h2:    half_cnt = 13'h0020;
				3'h3:    half_cnt = 13'h0010;
				3'h4:    half_cnt = 13'h0008;
				3'h5:    half_cnt = 13'h0004;
				default: half_cnt = 13'h0002;
			endcase
		end
	endfunction

	assign run  = serial_control_one[`CSP_CTL1_RUN];
	assign dir  = serial_control_one[`CSP_CTL1_DIR];
	assign mode = serial_control_one[`CSP_CTL1_MODE_HI:`CSP_CTL1_MODE_LO];
	assign ext  = (serial_control_one[`CSP_CTL1_SCK_HI:`CSP_CTL1_SCK_LO]
		== `CSP_SCK_EXT);
	// reserved mode 11 behaves as transmit and receive
	assign tx_mode  = (mode != `CSP_MODE_RX);
	assign rx_mode  = (mode != `CSP_MODE_TX);
	assign total    = {1'b0, serial_control_two} + 4'h1;
	assign done_all = (byte_cnt == total);

	// apb decode, one wait state so read data comes from a flop
	assign idx      = {2'h0, PADDR[7:2]};
	assign acc      = PSEL & PENABLE & PREADY;
	assign wr       = acc & PWRITE;
	assign rd       = acc & ~PWRITE;
	assign mapped   = (PADDR[1:0] == 2'h0) & (idx >= `CSP_IDX_CTL1)
		& (idx <= `CSP_IDX_DATA);
	assign hit_data = (idx == `CSP_IDX_DATA);
	assign abort    = wr & (idx == `CSP_IDX_CTL1)
		& PWDATA[`CSP_CTL1_ABORT];
	assign stat     = {active, shifting, tx_empty, rx_full,
		tx_err, rx_err, 2'h0};

	// external clock synchroniser, edge taken once stages two and three agree
	always @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			ck_s1 <= 1'b1;
			ck_s2 <= 1'b1;
			ck_s3 <= 1'b1;
			ck_st <= 1'b1;
			di_s1 <= 1'b1;
			di_s2 <= 1'b1;
			di_s3 <= 1'b1;
		end
		else
		begin
			ck_s1 <= SERIAL_CLOCK_PIN_IN;
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
			di_s1 <= SERIAL_DATA_IN;
			di_s2 <= di_s1;
			di_s3 <= di_s2;
			if (ck_s2 == ck_s3)
				ck_st <= ck_s3;
		end
	end

	// internal clock runs only while bytes remain or a byte is open
	assign gen  = active & ~ext & (~done_all | shifting);
	assign tick = gen & (div == half_cnt(serial_control_one[2:0]) - 13'h1);
	assign lead = active & (ext ? ((ck_s2 == ck_s3) & ck_st & ~ck_s3)
		: (tick & sck_int));
	assign trail = active & shifting & (ext
		? ((ck_s2 == ck_s3) & ~ck_st & ck_s3)
		: (tick & ~sck_int));
	assign load     = lead & ~shifting & ~done_all & ~(tx_mode & buf_empty);
	assign byte_end = trail & (bit_cnt == 3'h7);
	assign next_shreg = dir ? {di_s3, shreg[7:1]}
		: {shreg[6:0], di_s3};

	assign buf_push  = tx_mode ? (wr & hit_data) : byte_end;
	assign buf_wdata = tx_mode ? PWDATA[7:0] : next_shreg;
	assign buf_pop   = tx_mode ? load : (rd & hit_data);

	csp_buf u_buf
	(
		.clk   (REF_CLK),
		.rst   (SYS_RST),
		.push  (buf_push),
		.pop   (buf_pop),
		.wdata (buf_wdata),
		.rdata (buf_rdata),
		.empty (buf_empty),
		.full  ()
	);

	always @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h00000000;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY  <= PSEL & PENABLE & ~PREADY;
			PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
			if (PSEL & PENABLE & ~PREADY)
			begin
				case (idx)
					`CSP_IDX_CTL1: PRDATA <= {24'h0, serial_control_one};
					`CSP_IDX_CTL2: PRDATA <= {29'h0, serial_control_two};
					`CSP_IDX_STAT: PRDATA <= {24'h0, stat};
					`CSP_IDX_DATA: PRDATA <= {24'h0, buf_rdata};
					default:       PRDATA <= 32'h00000000;
				endcase
			end
		end
	end

	// register writes and the shift engine share one process
	always @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			serial_control_one     <= `CSP_CTL1_RST;
			serial_control_two     <= `CSP_CTL2_RST;
			active                 <= 1'b0;
			shifting               <= 1'b0;
			tx_empty               <= 1'b0;
			rx_full                <= 1'b0;
			tx_err                 <= 1'b0;
			rx_err                 <= 1'b0;
			bit_cnt                <= 3'h0;
			byte_cnt               <= 4'h0;
			shreg                  <= 8'hFF;
			div                    <= 13'h0000;
			sck_int                <= 1'b1;
			SERIAL_CLOCK_PIN_OUT   <= 1'b1;
			SERIAL_CLOCK_PIN_OE_N  <= 1'b1;
			SERIAL_DATA_OUTPUT_PIN <= 1'b1;
			TRANSFER_INTERRUPT     <= 1'b0;
		end
		else if (abort)
		begin
			// abort bit never stored, so it reads back as zero
			serial_control_one[`CSP_CTL1_RUN] <= 1'b0;
			active                 <= 1'b0;
			shifting               <= 1'b0;
			tx_empty               <= 1'b0;
			rx_full                <= 1'b0;
			tx_err                 <= 1'b0;
			rx_err                 <= 1'b0;
			bit_cnt                <= 3'h0;
			byte_cnt               <= 4'h0;
			div                    <= 13'h0000;
			sck_int                <= 1'b1;
			SERIAL_CLOCK_PIN_OUT   <= 1'b1;
			SERIAL_DATA_OUTPUT_PIN <= 1'b1;
			TRANSFER_INTERRUPT     <= 1'b0;
		end
		else
		begin
			TRANSFER_INTERRUPT    <= 1'b0;
			SERIAL_CLOCK_PIN_OE_N <= ext;
			if (wr & (idx == `CSP_IDX_CTL1))
			begin
				serial_control_one <= {PWDATA[7], 1'b0, PWDATA[5:0]};
				if (PWDATA[`CSP_CTL1_RUN] & ~active)
				begin
					active   <= 1'b1;
					// data line idles high until the first bit is loaded
					SERIAL_DATA_OUTPUT_PIN <= 1'b1;
					byte_cnt <= 4'h0;
					bit_cnt  <= 3'h0;
					rx_full  <= 1'b0;
					tx_empty <= 1'b0;
				end
			end
			if (wr & (idx == `CSP_IDX_CTL2))
				serial_control_two <= PWDATA[2:0];
			if (rd & hit_data & rx_mode & buf_empty)
				rx_full <= 1'b0;

			if (gen)
			begin
				div <= tick ? 13'h0000 : div + 13'h0001;
				if (tick)
					sck_int <= ~sck_int;
			end
			else
			begin
				div     <= 13'h0000;
				sck_int <= 1'b1;
			end
			SERIAL_CLOCK_PIN_OUT <= gen ? (tick ? ~sck_int : sck_int)
				: 1'b1;

			if (lead & ~shifting & tx_mode & buf_empty & ext)
			begin
				tx_err                 <= 1'b1;
				SERIAL_DATA_OUTPUT_PIN <= 1'b1;
			end
			else if (load)
			begin
				shifting <= 1'b1;
				shreg    <= tx_mode ? buf_rdata : 8'hFF;
				SERIAL_DATA_OUTPUT_PIN <= ~tx_mode
					| (dir ? buf_rdata[0] : buf_rdata[7]);
				if (tx_mode & (byte_cnt == total - 4'h1))
					tx_empty <= 1'b1;
			end
			else if (lead & shifting)
			begin
				SERIAL_DATA_OUTPUT_PIN <= ~tx_mode
					| (dir ? shreg[0] : shreg[7]);
				if (tx_mode & (bit_cnt == 3'h1)
					& (byte_cnt == total - 4'h1))
					TRANSFER_INTERRUPT <= 1'b1;
			end

			if (trail)
			begin
				shreg   <= next_shreg;
				bit_cnt <= bit_cnt + 3'h1;
			end
			if (byte_end)
			begin
				shifting <= 1'b0;
				byte_cnt <= byte_cnt + 4'h1;
				if (rx_mode & (byte_cnt == total - 4'h1))
				begin
					rx_full            <= 1'b1;
					TRANSFER_INTERRUPT <= 1'b1;
				end
				if (~run)
					active <= 1'b0;
			end
			else if (~run & ~shifting & active
				& ~(wr & (idx == `CSP_IDX_CTL1)))
				active <= 1'b0;
		end
	end
endmodule

// >>> testbench/csp_top_asserts.sv
`timescale 1ns/100ps
module csp_top_asserts
(
	// clock, reset
	input wire        REF_CLK,
	input wire        SYS_RST,
	// apb
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PWRITE,
	input wire [7:0]  PADDR,
	input wire [31:0] PWDATA,
	input wire [31:0] PRDATA,
	input wire        PREADY,
	input wire        PSLVERR,
	// serial
	input wire        SERIAL_CLOCK_PIN_IN,
	input wire        SERIAL_CLOCK_PIN_OUT,
	input wire        SERIAL_CLOCK_PIN_OE_N,
	input wire        SERIAL_DATA_IN,
	input wire        SERIAL_DATA_OUTPUT_PIN,
	input wire        TRANSFER_INTERRUPT
);
	reg  [7:0] ctl;
	wire       ck  = SERIAL_CLOCK_PIN_OUT;
	wire       so  = SERIAL_DATA_OUTPUT_PIN;
	wire       oen = SERIAL_CLOCK_PIN_OE_N;
	wire       irq = TRANSFER_INTERRUPT;
	wire [2:0] sck = ctl[2:0];
	wire       wr1 = PSEL & PENABLE & PREADY & PWRITE & (PADDR == 8'h58);
	// shadow of control one, abort bit never kept, abort clears run only
	always @(posedge REF_CLK or posedge SYS_RST)
		if (SYS_RST)
			ctl <= 8'h00;
		else if (wr1 && PWDATA[6])
			ctl <= ctl & 8'h7F;
		else if (wr1)
			ctl <= {PWDATA[7], 1'b0, PWDATA[5:0]};
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	wait_state_a: assert property
		(PSEL && PENABLE && !PREADY |=> PREADY) else $error("no ready");
	oe_ext_a: assert property
		(sck == 3'h7 && $past(sck) == 3'h7 |-> oen) else $error("oe on");
	clk_int_a: assert property
		($fell(ck) |-> !oen && sck != 3'h7) else $error("bad clock");
	half_one_a: assert property
		($fell(ck) && sck == 3'h1 |-> ##127 !ck ##1 ck) else $error("half");
	bit_edge_a: assert property
		($changed(so) && ctl[7] && $past(ctl[7]) && sck != 3'h7
		|-> !ck && $past(ck)) else $error("bit edge");
	irq_tx_a: assert property
		(irq && ctl[5:4] == 2'h0 && !oen |-> !ck ##1 !irq)
		else $error("irq");
	rx_idle_a: assert property
		(ctl[7] && ctl[5:4] == 2'h1 |-> so) else $error("rx out");
	abort_ck_a: assert property
		(wr1 && PWDATA[6] && sck != 3'h7 |-> ##[1:3] ck)
		else $error("abort clock");
	cover property (irq);
	cover property (PREADY && PSLVERR);
	cover property (wr1 && PWDATA[6]);
endmodule
bind csp_top csp_top_asserts CHK (.REF_CLK, .SYS_RST, .PSEL, .PENABLE,
	.PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
	.SERIAL_CLOCK_PIN_IN, .SERIAL_CLOCK_PIN_OUT, .SERIAL_CLOCK_PIN_OE_N,
	.SERIAL_DATA_IN, .SERIAL_DATA_OUTPUT_PIN, .TRANSFER_INTERRUPT);

// >>> testbench/csp_peer.sv
`timescale 1ns/100ps
module csp_peer
#(
	parameter HALF = 50
)
(
	// clock
	input  wire       clk,
	// link
	input  wire       pin,
	input  wire       so,
	output reg        si,
	output reg        drv,
	output reg  [7:0] got
);
	reg       pin_q;
	reg [7:0] pat;
	initial
	begin
		si = 1'b1;
		drv = 1'b1;
		got = 8'h00;
		pat = 8'h00;
		pin_q = 1'b1;
	end
	always @(posedge clk)
	begin
		pin_q <= pin;
		if (pin_q && !pin)
		begin
			si  <= pat[7];
			pat <= {pat[6:0], pat[7]};
		end
		if (!pin_q && pin)
			got <= {got[6:0], so};
	end
	// caller sets the count; extra pulses only where a test wants them
	task pulse(input integer n);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1)
			begin
				repeat (HALF) @(posedge clk);
				drv <= 1'b0;
				repeat (HALF) @(posedge clk);
				drv <= 1'b1;
			end
		end
	endtask
endmodule

// >>> testbench/csp_top_tb.sv
`timescale 1ns/100ps
`include "csp_defs.vh"
module csp_top_tb;
	localparam [7:0] C1 = `CSP_IDX_CTL1 << 2;
	localparam [7:0] C2 = `CSP_IDX_CTL2 << 2;
	localparam [7:0] CS = `CSP_IDX_STAT << 2;
	localparam [7:0] CD = `CSP_IDX_DATA << 2;
	reg         clk, rst, psel, pen, pwr, er, ck_q;
	reg  [7:0]  padr;
	reg  [31:0] pwd, rd;
	wire [31:0] prd;
	wire        prdy, perr, ck, oen, so, irq, si, drv;
	wire [7:0]  got;
	wire        pin = oen ? drv : ck;
	integer     bad_count, checked, n, i, falls, firq, fb;
	csp_top DUT (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
		.PREADY(prdy), .PSLVERR(perr), .SERIAL_CLOCK_PIN_IN(pin),
		.SERIAL_CLOCK_PIN_OUT(ck), .SERIAL_CLOCK_PIN_OE_N(oen),
		.SERIAL_DATA_IN(si), .SERIAL_DATA_OUTPUT_PIN(so),
		.TRANSFER_INTERRUPT(irq));
	csp_peer PEER (.clk(clk), .pin(pin), .so(so), .si(si), .drv(drv),
		.got(got));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		ck_q <= ck;
		if (ck_q && !ck)
			falls <= falls + 1;
		if (irq)
			firq <= falls + (ck_q && !ck);
	end
	task test_done;
		begin
			$display("checks %0d bad %0d", checked, bad_count);
			if (bad_count == 0 && checked > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] s, input [31:0] e);
		begin
			checked = checked + 1;
			if (s !== e)
			begin
				bad_count = bad_count + 1;
				$display("BAD %s exp %h seen %h", nm, e, s);
			end
		end
	endtask
	task tmo(input integer c);
		if (c >= 20000)
		begin
			chk("wait", 0, 1);
			test_done;
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		integer c;
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwr <= w;
			padr <= a;
			pwd <= d;
			@(posedge clk);
			pen <= 1'b1;
			c = 0;
			do
			begin
				@(posedge clk);
				c = c + 1;
			end
			while (prdy !== 1'b1 && c < 20000);
			tmo(c);
			rd = prd;
			er = perr;
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask
	task rchk(input string nm, input [7:0] a, input [31:0] e);
		begin
			apb(1'b0, a, 0);
			chk(nm, rd, e);
		end
	endtask
	// start, stop inside the service window, then wait for idle
	task run(input [7:0] c, input tx);
		begin
			fb = falls;
			apb(1'b1, C1, c);
			for (n = 0; irq !== 1'b1 && n < 20000; n = n + 1)
				@(posedge clk);
			tmo(n);
			apb(1'b1, C1, c & 8'h7F);
			apb(1'b0, CS, 0);
			if (tx)
				chk("busy", rd[7], 1);
			for (n = 0; rd[7] !== 1'b0 && n < 20000; n = n + 1)
				apb(1'b0, CS, 0);
			tmo(n);
		end
	endtask
	initial
	begin
		{rst, ck_q} = 2'b11;
		{psel, pen, pwr, padr, pwd} = 0;
		{bad_count, checked, falls, firq} = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rchk("ctl1", C1, 0);
		rchk("ctl2", C2, 0);
		apb(1'b0, 8'h00, 0);
		chk("slverr", er, 1);
		// rates 000 and 001; abort lands in the high phase after the first low phase
		for (i = 0; i < 2; i = i + 1)
		begin
			apb(1'b1, C2, 0);
			apb(1'b1, CD, 8'h5A);
			apb(1'b1, C1, 8'h80 | i);
			for (n = 0; ck !== 1'b0 && n < 20000; n = n + 1)
				@(posedge clk);
			for (n = 0; ck === 1'b0 && n < 20000; n = n + 1)
				@(posedge clk);
			chk("low", n, 4096 >> (i * 5));
			apb(1'b1, C1, 8'h40 | i);
			rchk("stat", CS, 0);
			rchk("ctl1", C1, i);
			repeat (130) @(posedge clk);
			chk("sck", ck, 1);
		end
		apb(1'b1, C2, 1);
		apb(1'b1, CD, 8'hA5);
		apb(1'b1, CD, 8'h3C);
		run(8'h81, 1'b1);
		chk("irq", firq - fb, 10);
		chk("got", got, 8'h3C);
		chk("sck", ck, 1);
		apb(1'b1, C2, 0);
		apb(1'b1, CD, 8'h35);
		run(8'h89, 1'b1);
		chk("got", got, 8'hAC);
		PEER.pat <= 8'h0D;
		run(8'h99, 1'b0);
		rchk("rx", CD, 8'hB0);
		// combined mode: transmit side must still shift the loaded byte
		apb(1'b1, C1, 8'h21);
		apb(1'b1, CD, 8'h96);
		run(8'hA1, 1'b1);
		chk("trx", got, 8'h96);
		// mode first, so the data write lands in the transmit buffer
		apb(1'b1, C1, 8'h07);
		apb(1'b1, CD, 8'hC3);
		apb(1'b1, C1, 8'h87);
		PEER.pulse(8);
		apb(1'b0, CS, 0);
		chk("act", rd[7], 1);
		chk("oe", oen, 1);
		chk("got", got, 8'hC3);
		PEER.pulse(1);
		apb(1'b0, CS, 0);
		chk("txerr", rd[3], 1);
		chk("so", so, 1);
		apb(1'b1, C1, 8'h47);
		rchk("stat", CS, 0);
		rchk("ctl1", C1, 8'h07);
		test_done;
	end
endmodule
